// >>> verilog/uitf_pkg.sv
// Purpose: shared constants and types for the unsigned integer to float unit
// Assumes: one clock, synchronous active-low reset, AXI4-Lite register access
// Notes: flag vector layout is shared by status word and probe results
package uitf_pkg;

    // opcodes of this group
    localparam logic [7:0] UITF_OPC_CONV = 8'h7F;
    localparam logic [7:0] UITF_OPC_CONV_RZ = 8'h77;
    localparam logic [7:0] UITF_OPC_PROBE = 8'h80;
    localparam logic [7:0] UITF_OPC_PROBE_RZ = 8'h78;

    // exception flag vector
    localparam int UITF_FLAG_W = 6;
    localparam int UITF_FLAG_INX = 1;
    localparam logic [5:0] UITF_FLAG_INX_MASK = 6'h02;

    // rounding mode encodings
    localparam logic [1:0] UITF_RM_NEAREST = 2'h0;
    localparam logic [1:0] UITF_RM_ZERO = 2'h1;
    localparam logic [1:0] UITF_RM_POS = 2'h2;
    localparam logic [1:0] UITF_RM_NEG = 2'h3;

    // status word fields
    localparam int UITF_PSW_FLAG_LSB = 0;
    localparam int UITF_PSW_RM_LSB = 8;
    localparam logic [5:0] UITF_PSW_FLAG_RST = 6'h00;
    localparam logic [1:0] UITF_PSW_RM_RST = 2'h0;

    // register offsets (byte addresses)
    localparam logic [3:0] UITF_OFS_PSW = 4'h0;
    localparam logic [3:0] UITF_OFS_LAST = 4'h4;

    // AXI responses
    localparam logic [1:0] UITF_RESP_OKAY = 2'h0;
    localparam logic [1:0] UITF_RESP_SLVERR = 2'h2;

    // float format, pipeline latency and destination width
    localparam logic [7:0] UITF_EXP_BIAS = 8'h7F;
    localparam int UITF_LATENCY = 3;
    localparam int UITF_DEST_W = 7;

    typedef enum logic [1:0] {
        UITF_OP_CONV,
        UITF_OP_CONV_RZ,
        UITF_OP_PROBE,
        UITF_OP_PROBE_RZ
    } uitf_op_e;

    typedef struct packed {
        logic valid;
        uitf_op_e kind;
        logic [UITF_DEST_W-1:0] dest;
        logic [31:0] data;
        logic [UITF_FLAG_W-1:0] flags;
        logic [1:0] rmode;
    } uitf_stage_s;

endpackage

// >>> verilog/uitf_cvt.sv
// Purpose: combinational unsigned 32-bit to single-precision converter
// Assumes: operand is unsigned, result is never negative
// Notes: only inexact can arise from this conversion
`timescale 1ns/100ps
`default_nettype none
module uitf_cvt
    import uitf_pkg::*;
(
    // operand and mode
    input wire logic [31:0] source_operand,
    input wire logic [1:0] rmode,
    // result
    output logic [31:0] result,
    output logic [UITF_FLAG_W-1:0] flags
);

    logic [4:0] lead;
    logic [31:0] norm;
    logic [22:0] mant;
    logic grd;
    logic stk;
    logic inexact_flag;
    logic up;
    logic [7:0] biased;
    logic [31:0] packed_val;

    // leading one position
    always_comb begin
        lead = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (source_operand[i]) begin
                lead = 5'(i);
            end
        end
    end

    assign norm = source_operand << (5'h1F - lead);
    assign mant = norm[30:8];
    assign grd = norm[7];
    assign stk = |norm[6:0];
    assign inexact_flag = grd | stk;
    assign biased = UITF_EXP_BIAS + {3'h0, lead};

    // round increment per mode
    always_comb begin
        case (rmode)
            UITF_RM_NEAREST: up = grd & (stk | mant[0]);
            UITF_RM_ZERO: up = 1'b0;
            UITF_RM_POS: up = inexact_flag;
            UITF_RM_NEG: up = 1'b0;
            default: up = 1'b0;
        endcase
    end

    // carry out of mantissa lands in exponent
    assign packed_val = {1'b0, biased, mant} + {31'h00000000, up};
    assign result = (source_operand == 32'h00000000) ? 32'h00000000 : packed_val;
    assign flags = inexact_flag ? UITF_FLAG_INX_MASK : 6'h00;

endmodule
`default_nettype wire

// >>> verilog/uitf_unit.sv
// Purpose: unsigned integer to float unit with status word and AXI4-Lite access
// Assumes: issue logic sends only opcodes of this group to this slot
// Notes: three-cycle pipeline, writeback and flag update on the same edge
//
// Functional notes
// - default convert rounds by the status-word rounding mode
// - truncating convert always rounds toward zero, ignores mode bits
// - probe writes flag vector, status-word layout, inexact is 0x02
// - probe leaves status-word flags untouched, writes destination and the last-flags register
// - converting ops set matching status-word flags on exception
// - flags are sticky; only explicit status-word write clears them
// - simultaneous flag updates are ORed with existing flag values
// - flag update coincides with destination write, latency three cycles
// - guard bit zero keeps destination, guard bit one writes it
// - guard bit zero on convert suppresses write and flag change
// - truncating probe returns flags, rounds toward zero, keeps status word
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module uitf_unit
    import uitf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // issue port
    input wire logic issue_valid,
    input wire logic [7:0] issue_opcode,
    input wire logic [31:0] source_operand,
    input wire logic guard_present,
    input wire logic [31:0] guard_value,
    input wire logic [UITF_DEST_W-1:0] issue_dest,
    // flag updates from other floating-point units
    input wire logic [UITF_FLAG_W-1:0] ext_flag_set,
    // writeback port
    output logic wb_valid,
    output logic [UITF_DEST_W-1:0] wb_dest,
    output logic [31:0] wb_data,
    // status word view
    output logic [31:0] program_status_word,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // opcode decode

    function automatic logic op_known(input logic [7:0] opc);
        op_known = (opc == UITF_OPC_CONV) || (opc == UITF_OPC_CONV_RZ) ||
                   (opc == UITF_OPC_PROBE) || (opc == UITF_OPC_PROBE_RZ);
    endfunction

    function automatic uitf_op_e op_kind(input logic [7:0] opc);
        case (opc)
            UITF_OPC_CONV: op_kind = UITF_OP_CONV;
            UITF_OPC_CONV_RZ: op_kind = UITF_OP_CONV_RZ;
            UITF_OPC_PROBE: op_kind = UITF_OP_PROBE;
            UITF_OPC_PROBE_RZ: op_kind = UITF_OP_PROBE_RZ;
            default: op_kind = UITF_OP_CONV;
        endcase
    endfunction

    logic [UITF_FLAG_W-1:0] flags_r;
    logic [UITF_FLAG_W-1:0] flags_nxt;
    logic [1:0] rmode_r;
    logic [1:0] rmode_nxt;
    logic [31:0] last_r;
    uitf_stage_s sa_r;
    uitf_stage_s sa_nxt;
    uitf_stage_s sb_r;
    uitf_stage_s sb_nxt;
    logic wb_probe_r;
    logic guard_ok;
    uitf_op_e issue_kind;
    logic [1:0] issue_rmode;
    logic [31:0] cvt_result;
    logic [UITF_FLAG_W-1:0] cvt_flags;
    logic sb_is_probe;
    logic commit_conv;
    logic [UITF_FLAG_W-1:0] hw_set;

    ////////////////////////////////////////////////////////////////////////
    // stage a: issue capture

    assign guard_ok = !guard_present || guard_value[0];
    assign issue_kind = op_kind(issue_opcode);
    // truncating forms force toward zero
    assign issue_rmode = (issue_kind == UITF_OP_CONV_RZ || issue_kind == UITF_OP_PROBE_RZ) ?
                         UITF_RM_ZERO : rmode_r;

    always_comb begin
        sa_nxt = '0;
        sa_nxt.valid = issue_valid && op_known(issue_opcode) && guard_ok;
        sa_nxt.kind = issue_kind;
        sa_nxt.dest = issue_dest;
        sa_nxt.data = source_operand;
        sa_nxt.rmode = issue_rmode;
    end

    ////////////////////////////////////////////////////////////////////////
    // stage b: conversion

    uitf_cvt u_cvt (
        .source_operand(sa_r.data),
        .rmode(sa_r.rmode),
        .result(cvt_result),
        .flags(cvt_flags)
    );

    assign sb_is_probe = (sa_r.kind == UITF_OP_PROBE) || (sa_r.kind == UITF_OP_PROBE_RZ);

    always_comb begin
        sb_nxt = sa_r;
        sb_nxt.flags = cvt_flags;
        sb_nxt.data = sb_is_probe ? {26'h0000000, cvt_flags} : cvt_result;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sa_r <= '0;
            sb_r <= '0;
        end else begin
            sa_r <= sa_nxt;
            sb_r <= sb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage c: writeback and flag merge

    assign commit_conv = sb_r.valid &&
                         (sb_r.kind == UITF_OP_CONV || sb_r.kind == UITF_OP_CONV_RZ);
    assign hw_set = ext_flag_set | (commit_conv ? sb_r.flags : 6'h00);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wb_valid <= 1'b0;
            wb_dest <= '0;
            wb_data <= 32'h00000000;
            wb_probe_r <= 1'b0;
            last_r <= 32'h00000000;
        end else begin
            wb_valid <= sb_r.valid;
            wb_dest <= sb_r.dest;
            wb_data <= sb_r.data;
            wb_probe_r <= sb_r.valid && !commit_conv;
            if (sb_r.valid) begin
                last_r <= {26'h0000000, sb_r.flags};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic aw_hold_r;
    logic [3:0] awaddr_r;
    logic w_hold_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    logic wr_psw;
    logic wr_hit;
    logic rd_fire;
    logic rd_psw;
    logic rd_last;
    logic [31:0] rd_mux;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_psw = wr_fire && (awaddr_r == UITF_OFS_PSW);
    assign wr_hit = wr_psw || (awaddr_r == UITF_OFS_LAST);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_psw = s_axi_araddr == UITF_OFS_PSW;
    assign rd_last = s_axi_araddr == UITF_OFS_LAST;
    assign rd_mux = rd_psw ? program_status_word : (rd_last ? last_r : 32'h00000000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 4'h0;
            w_hold_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= UITF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? UITF_RESP_OKAY : UITF_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= UITF_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= (rd_psw || rd_last) ? UITF_RESP_OKAY : UITF_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word

    always_comb begin
        flags_nxt = flags_r;
        rmode_nxt = rmode_r;
        if (wr_psw && wstrb_r[0]) begin
            flags_nxt = wdata_r[UITF_PSW_FLAG_LSB +: UITF_FLAG_W];
        end
        if (wr_psw && wstrb_r[1]) begin
            rmode_nxt = wdata_r[UITF_PSW_RM_LSB +: 2];
        end
        // hardware set wins over a clearing write
        flags_nxt = flags_nxt | hw_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= UITF_PSW_FLAG_RST;
            rmode_r <= UITF_PSW_RM_RST;
        end else begin
            flags_r <= flags_nxt;
            rmode_r <= rmode_nxt;
        end
    end

    assign program_status_word = {22'h000000, rmode_r, 2'h0, flags_r};

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic issue_ok;
    assign issue_ok = issue_valid && op_known(issue_opcode);

    AST_RN_CONV: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && guard_ok && issue_opcode == UITF_OPC_CONV && rmode_r == UITF_RM_NEAREST &&
        source_operand == 32'hFFFFFFFF |-> ##3 wb_valid && wb_data == 32'h4F800000)
        else $error("nearest convert of all ones wrong");

    AST_RZ_CONV: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && guard_ok && issue_opcode == UITF_OPC_CONV_RZ &&
        source_operand == 32'hFFFFFFFF |-> ##3 wb_valid && wb_data == 32'h4F7FFFFF)
        else $error("truncating convert rounded up");

    AST_PROBE_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
        wb_valid && wb_probe_r |-> wb_data[31:6] == 26'h0000000)
        else $error("probe result has bits above flags");

    AST_PROBE_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn)
        sb_r.valid && !commit_conv && !wr_psw && ext_flag_set == 6'h00 |=> $stable(flags_r))
        else $error("probe changed status flags");

    AST_INX_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        commit_conv && sb_r.flags[UITF_FLAG_INX] |=> flags_r[UITF_FLAG_INX] && wb_valid)
        else $error("inexact not raised by convert");

    AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_psw |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("flag cleared without status write");

    AST_OR_MERGE: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_flag_set != 6'h00 |=> (flags_r & $past(ext_flag_set)) == $past(ext_flag_set))
        else $error("simultaneous flag update lost");

    AST_GUARD_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && guard_present && guard_value[0] |-> ##3 wb_valid &&
        wb_dest == $past(issue_dest, 3))
        else $error("guarded op not written after three cycles");

    AST_GUARD_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_valid && guard_present && !guard_value[0] |-> ##2 !commit_conv ##1 !wb_valid)
        else $error("guard false op had an effect");

    AST_NO_GUARD: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && !guard_present |-> ##3 wb_valid)
        else $error("unguarded op not written");

    AST_PROBE_INX: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && guard_ok && issue_opcode == UITF_OPC_PROBE &&
        source_operand == 32'hFFFFFFFF |-> ##3 wb_valid && wb_data == 32'h00000002)
        else $error("probe of all ones missed inexact");

    AST_PROBE_RZ: assert property (@(posedge aclk) disable iff (!aresetn)
        issue_ok && guard_ok && issue_opcode == UITF_OPC_PROBE_RZ &&
        source_operand == 32'h7FFFFFF1 |-> ##3 wb_valid && wb_data == 32'h00000002)
        else $error("truncating probe missed inexact");

endmodule
`default_nettype wire

// >>> sim/uitf_rf_model.sv
// Purpose: register file model on the far side of the writeback port
// Assumes: one write per cycle, taken at the rising edge with wb_valid high
// Notes: entries start at a marker pattern so untouched entries are visible
`timescale 1ns/100ps
`default_nettype none
module uitf_rf_model
    import uitf_pkg::*;
(
    // clock
    input wire logic aclk,
    // writeback from the unit
    input wire logic wb_valid,
    input wire logic [UITF_DEST_W-1:0] wb_dest,
    input wire logic [31:0] wb_data
);
    logic [31:0] regs [0:(1<<UITF_DEST_W)-1];
    ////////////////////////////////////////////////////////////////////////
    // marker fill
    initial begin
        for (int i = 0; i < (1<<UITF_DEST_W); i++) begin
            regs[i] = 32'hA5A50000 | i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // destination write
    always @(posedge aclk) begin
        if (wb_valid) begin
            regs[wb_dest] <= wb_data;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for the unsigned integer to float unit
// Assumes: issue slot and AXI4-Lite master are modelled here
// Notes: a scoreboard checks every writeback against issue order and timing
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module tb
    import uitf_pkg::*;
;
    logic aclk, aresetn, issue_valid, guard_present;
    logic [7:0] issue_opcode;
    logic [31:0] source_operand, guard_value, wb_data, program_status_word;
    logic [UITF_DEST_W-1:0] issue_dest, wb_dest, e_dst;
    logic [UITF_FLAG_W-1:0] ext_flag_set;
    logic wb_valid, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [3:0] awa, ara, wst;
    logic [31:0] wd, rd, e_dat;
    logic [1:0] bresp, rresp;
    int mismatches = 0, cmp_count = 0, cyc = 0, e_cyc;
    int q_cyc[$];
    logic [UITF_DEST_W-1:0] q_dst[$];
    logic [31:0] q_dat[$];
    uitf_unit DUT (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
        .issue_opcode(issue_opcode), .source_operand(source_operand),
        .guard_present(guard_present), .guard_value(guard_value), .issue_dest(issue_dest),
        .ext_flag_set(ext_flag_set), .wb_valid(wb_valid), .wb_dest(wb_dest),
        .wb_data(wb_data), .program_status_word(program_status_word),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    uitf_rf_model rf (.aclk(aclk), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data));
    ////////////////////////////////////////////////////////////////////////
    // clock, cycle count, scoreboard
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    always @(negedge aclk) begin
        if (wb_valid === 1'b1) begin
            if (q_cyc.size() == 0) begin
                mismatches++;
                $display("unexpected write at %0t: got %h exp %h", $time, wb_data, 32'h0);
            end else begin
                e_cyc = q_cyc.pop_front();
                e_dst = q_dst.pop_front();
                e_dat = q_dat.pop_front();
                `CHK(cyc, e_cyc)
                `CHK(wb_dest, e_dst)
                `CHK(wb_data, e_dat)
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // bus and issue tasks
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] resp);
        @(posedge aclk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; wst <= s; br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (awv | wv);
        while (bv !== 1'b1) @(posedge aclk);
        br <= 1'b0;
        `CHK(bresp, resp)
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge aclk);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        rr <= 1'b0;
        `CHK(rd, d)
        `CHK(rresp, resp)
    endtask
    // issue logic of the one slot that holds this unit
    task automatic issue(input logic [7:0] op, input logic [31:0] src, input logic gp,
        input logic [31:0] gv, input logic [UITF_DEST_W-1:0] dst, input logic [31:0] exp);
        @(posedge aclk);
        issue_valid <= 1'b1; issue_opcode <= op; source_operand <= src;
        guard_present <= gp; guard_value <= gv; issue_dest <= dst;
        if (!gp || gv[0]) begin
            q_cyc.push_back(cyc + UITF_LATENCY + 1); q_dst.push_back(dst); q_dat.push_back(exp);
        end
    endtask
    task automatic drain();
        @(posedge aclk);
        issue_valid <= 1'b0;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        `CHK(q_cyc.size(), 0)
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        `CHK(program_status_word, 32'h0)
        axi_rd(UITF_OFS_PSW, 32'h0, UITF_RESP_OKAY);
        axi_rd(4'h8, 32'h0, UITF_RESP_SLVERR);
    endtask
    task automatic t_convert();
        logic [7:0] op[7] = '{8'h7F, 8'h7F, 8'h77, 8'h77, 8'h7F, 8'h7F, 8'h77};
        logic [31:0] s[7] = '{32'h3, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h7FFFFFFF,
            32'h80000000, 32'h7FFFFFF1};
        logic [31:0] r[7] = '{32'h40400000, 32'h4F800000, 32'h4F7FFFFF, 32'h4EFFFFFF,
            32'h4F000000, 32'h4F000000, 32'h4EFFFFFF};
        for (int i = 0; i < 7; i++) issue(op[i], s[i], 1'b0, 32'h0, 7'(i + 1), r[i]);
        drain();
        `CHK(program_status_word, 32'h00000002)
    endtask
    task automatic t_probe();
        axi_wr(UITF_OFS_PSW, 32'h0, 4'h1, UITF_RESP_OKAY);
        `CHK(program_status_word, 32'h0)
        issue(UITF_OPC_PROBE, 32'hFFFFFFFF, 1'b0, 32'h0, 7'h20, 32'h2);
        issue(UITF_OPC_PROBE, 32'h3, 1'b0, 32'h0, 7'h21, 32'h0);
        issue(UITF_OPC_PROBE_RZ, 32'h7FFFFFF1, 1'b0, 32'h0, 7'h22, 32'h2);
        issue(UITF_OPC_PROBE_RZ, 32'h80000000, 1'b0, 32'h0, 7'h23, 32'h0);
        drain();
        `CHK(program_status_word, 32'h0)
        `CHK(rf.regs[7'h20], 32'h2)
    endtask
    task automatic t_guard();
        issue(UITF_OPC_CONV, 32'hFFFFFFFF, 1'b1, 32'hFFFFFFFE, 7'h30, 32'h0);
        issue(UITF_OPC_PROBE, 32'hFFFFFFFF, 1'b1, 32'h0, 7'h31, 32'h0);
        issue(UITF_OPC_CONV_RZ, 32'h3, 1'b1, 32'h1, 7'h32, 32'h40400000);
        drain();
        `CHK(program_status_word, 32'h0)
        `CHK(rf.regs[7'h30], 32'hA5A50030)
        `CHK(rf.regs[7'h32], 32'h40400000)
    endtask
    task automatic t_sticky();
        issue(UITF_OPC_CONV, 32'hFFFFFFFF, 1'b0, 32'h0, 7'h40, 32'h4F800000);
        @(posedge aclk);
        issue_valid <= 1'b0;
        @(posedge aclk);
        ext_flag_set <= 6'h04;
        @(posedge aclk);
        ext_flag_set <= 6'h00;
        @(negedge aclk);
        `CHK(program_status_word, 32'h00000006)
        issue(UITF_OPC_CONV, 32'h3, 1'b0, 32'h0, 7'h41, 32'h40400000);
        drain();
        `CHK(program_status_word, 32'h00000006)
        axi_wr(UITF_OFS_PSW, 32'h10, 4'h1, UITF_RESP_OKAY);
        `CHK(program_status_word, 32'h00000010)
    endtask
    task automatic t_mode();
        axi_wr(UITF_OFS_PSW, 32'h100, 4'h2, UITF_RESP_OKAY);
        issue(UITF_OPC_CONV, 32'hFFFFFFFF, 1'b0, 32'h0, 7'h50, 32'h4F7FFFFF);
        drain();
        axi_wr(UITF_OFS_PSW, 32'h200, 4'h2, UITF_RESP_OKAY);
        issue(UITF_OPC_CONV, 32'h7FFFFFF1, 1'b0, 32'h0, 7'h51, 32'h4F000000);
        issue(UITF_OPC_CONV_RZ, 32'hFFFFFFFF, 1'b0, 32'h0, 7'h52, 32'h4F7FFFFF);
        drain();
        axi_wr(UITF_OFS_PSW, 32'h300, 4'h2, UITF_RESP_OKAY);
        issue(UITF_OPC_CONV, 32'hFFFFFFFF, 1'b0, 32'h0, 7'h53, 32'h4F7FFFFF);
        drain();
        axi_wr(UITF_OFS_LAST, 32'hFFFFFFFF, 4'hF, UITF_RESP_OKAY);
        axi_wr(4'hC, 32'hFFFFFFFF, 4'hF, UITF_RESP_SLVERR);
        axi_rd(UITF_OFS_PSW, 32'h00000312, UITF_RESP_OKAY);
        axi_rd(UITF_OFS_LAST, 32'h00000002, UITF_RESP_OKAY);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // verdict, watchdog, main sequence
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        results();
    end
    initial begin
        aresetn = 1'b0; issue_valid = 1'b0; issue_opcode = 8'h00; source_operand = 32'h0;
        guard_present = 1'b0; guard_value = 32'h0; issue_dest = '0; ext_flag_set = '0;
        awv = 1'b0; awa = 4'h0; wv = 1'b0; wd = 32'h0; wst = 4'h0; br = 1'b0;
        arv = 1'b0; ara = 4'h0; rr = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_convert();
        t_probe();
        t_guard();
        t_sticky();
        t_mode();
        results();
    end
endmodule
`default_nettype wire
